// *** inc/asram_pkg.sv ***
// Package with pin bundles, request types and timing constants of the memory host.
package asram_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int WORDS = 1024;
    localparam int INDEX_W = 10;
    localparam int DATA_W = 4;

    // ****************************************************************
    // Timing, figures in picoseconds and derived cycle counts
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int INDEX_TO_OUTPUT_DELAY_PS = 2700;
    localparam int SELECT_TO_OUTPUT_DELAY_PS = 2000;
    localparam int DESELECT_TO_LOW_DELAY_PS = 2000;
    localparam int OUTPUT_KEEP_TIME_PS = 1000;
    localparam int WRITE_PULSE_MIN_PS = 2500;
    localparam int DATA_SETUP_TO_STROBE_RISE_PS = 2000;
    localparam int STROBE_RISE_HOLD_PS = 1000;
    localparam int WRITE_RECOVERY_DELAY_PS = 2700;

    // Least times round up, never below one cycle.
    function automatic int cycles_up(input int ps);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ACCESS_PS = (INDEX_TO_OUTPUT_DELAY_PS > SELECT_TO_OUTPUT_DELAY_PS) ?
        INDEX_TO_OUTPUT_DELAY_PS : SELECT_TO_OUTPUT_DELAY_PS;
    localparam int ACCESS_CYCLES = cycles_up(ACCESS_PS);
    localparam int PULSE_CYCLES = cycles_up(WRITE_PULSE_MIN_PS);
    localparam int DATA_SETUP_CYCLES = cycles_up(DATA_SETUP_TO_STROBE_RISE_PS);
    localparam int HOLD_CYCLES = cycles_up(STROBE_RISE_HOLD_PS);
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W = 4;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic RST_SELECT_N = 1'b1;
    localparam logic RST_STROBE_N = 1'b1;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [INDEX_W-1:0] word_index;
        logic [DATA_W-1:0] write_data_in;
        logic select_n;
        logic write_strobe_n;
    } asram_pins_t;

    typedef struct packed {
        logic write;
        logic [INDEX_W-1:0] index;
        logic [DATA_W-1:0] wdata;
    } asram_req_t;

    typedef struct packed {
        logic write;
        logic [DATA_W-1:0] rdata;
    } asram_rsp_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_READ
    } asram_state_t;

endpackage

// *** hdl/asram_host.sv ***
// Host controller that runs reads and writes on the asynchronous 1K x 4 memory pins.
module asram_host #(
    parameter int INDEX_W = asram_pkg::INDEX_W, // Word index width.
    parameter int DATA_W = asram_pkg::DATA_W // Data width.
) (
    input wire logic clk, // 200 MHz clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic req_valid, // Request offered.
    input wire asram_pkg::asram_req_t req, // Request payload.
    output asram_pkg::asram_rsp_t rsp, // Answer payload.
    output logic rsp_valid, // One-cycle answer pulse.
    output logic req_ready, // Host can take a request.
    output asram_pkg::asram_pins_t pins, // Pins driven to the memory.
    input wire logic [DATA_W-1:0] read_data_out // Memory data outputs.
);

    // ****************************************************************
    // Input synchroniser
    // ****************************************************************
    logic [DATA_W-1:0] rd_sync1;
    logic [DATA_W-1:0] rd_sync2;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_sync1 <= '0;
            rd_sync2 <= '0;
        end else begin
            rd_sync1 <= read_data_out;
            rd_sync2 <= rd_sync1;
        end
    end

    // ****************************************************************
    // Access sequencer
    // ****************************************************************
    asram_pkg::asram_state_t state;
    asram_pkg::asram_state_t next_state;
    asram_pkg::asram_pins_t next_pins;
    asram_pkg::asram_rsp_t next_rsp;
    logic next_rsp_valid;
    logic next_req_ready;
    logic [asram_pkg::CNT_W-1:0] cnt;
    logic [asram_pkg::CNT_W-1:0] next_cnt;
    logic op_write;
    logic next_op_write;

    localparam logic [asram_pkg::CNT_W-1:0] PULSE_LAST = asram_pkg::CNT_W'(
        ((asram_pkg::PULSE_CYCLES > asram_pkg::DATA_SETUP_CYCLES) ?
        asram_pkg::PULSE_CYCLES : asram_pkg::DATA_SETUP_CYCLES) - 1);
    localparam logic [asram_pkg::CNT_W-1:0] HOLD_LAST =
        asram_pkg::CNT_W'(asram_pkg::HOLD_CYCLES - 1);
    // The wait covers the slower of the select and index delays plus the synchroniser.
    localparam logic [asram_pkg::CNT_W-1:0] READ_LAST =
        asram_pkg::CNT_W'(asram_pkg::ACCESS_CYCLES + asram_pkg::SYNC_STAGES - 1);

    always_comb begin
        next_state = state;
        next_pins = pins;
        next_rsp = rsp;
        next_rsp_valid = 1'b0;
        next_cnt = cnt;
        next_op_write = op_write;
        case (state)
            asram_pkg::ST_IDLE: begin
                if (req_valid && req_ready) begin
                    // Index and select go out a full cycle before any strobe edge.
                    next_pins.word_index = req.index;
                    next_pins.write_data_in = req.wdata;
                    next_pins.select_n = 1'b0;
                    next_pins.write_strobe_n = 1'b1;
                    next_op_write = req.write;
                    if (req.write) begin
                        next_state = asram_pkg::ST_SETUP;
                    end else begin
                        next_cnt = READ_LAST;
                        next_state = asram_pkg::ST_READ;
                    end
                end
            end
            asram_pkg::ST_SETUP: begin
                next_pins.write_strobe_n = 1'b0;
                next_cnt = PULSE_LAST;
                next_state = asram_pkg::ST_STROBE;
            end
            asram_pkg::ST_STROBE: begin
                if (cnt == '0) begin
                    // Data has been stable since setup, well ahead of this rising edge.
                    next_pins.write_strobe_n = 1'b1;
                    next_cnt = HOLD_LAST;
                    next_state = asram_pkg::ST_HOLD;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            asram_pkg::ST_HOLD: begin
                if (cnt == '0) begin
                    next_pins.select_n = 1'b1;
                    next_rsp.write = 1'b1;
                    next_rsp_valid = 1'b1;
                    next_state = asram_pkg::ST_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            asram_pkg::ST_READ: begin
                if (cnt == '0) begin
                    next_rsp.write = 1'b0;
                    next_rsp.rdata = rd_sync2;
                    next_rsp_valid = 1'b1;
                    next_pins.select_n = 1'b1;
                    next_state = asram_pkg::ST_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: begin
                next_pins.select_n = 1'b1;
                next_pins.write_strobe_n = 1'b1;
                next_state = asram_pkg::ST_IDLE;
            end
        endcase
        next_req_ready = (next_state == asram_pkg::ST_IDLE);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= asram_pkg::ST_IDLE;
            pins <= '{word_index: '0, write_data_in: '0,
                select_n: asram_pkg::RST_SELECT_N, write_strobe_n: asram_pkg::RST_STROBE_N};
            rsp <= '0;
            rsp_valid <= 1'b0;
            req_ready <= 1'b1;
            cnt <= '0;
            op_write <= 1'b0;
        end else begin
            state <= next_state;
            pins <= next_pins;
            rsp <= next_rsp;
            rsp_valid <= next_rsp_valid;
            req_ready <= next_req_ready;
            cnt <= next_cnt;
            op_write <= next_op_write;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_strobe_setup_ok: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(pins.write_strobe_n) |-> !pins.select_n && !$past(pins.select_n)
            && $stable(pins.word_index))
        else $error("Index or select not settled before the strobe fell.");

    a_strobe_pulse_width: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(pins.write_strobe_n) |=> $rose(pins.write_strobe_n))
        else $error("Write strobe pulse has the wrong width.");

    a_data_setup_ok: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(pins.write_strobe_n) |-> $stable(pins.write_data_in)
            && $past(pins.write_data_in, 1) == $past(pins.write_data_in, 2))
        else $error("Write data moved too close to the strobe rise.");

    a_data_hold_ok: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(pins.write_strobe_n) |=> $stable(pins.write_data_in))
        else $error("Write data changed right after the strobe rose.");

    a_index_hold_ok: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(pins.write_strobe_n) |-> !pins.select_n && $stable(pins.word_index)
            ##1 $stable(pins.word_index))
        else $error("Index or select released too early after the write.");

    a_write_then_done: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(pins.write_strobe_n) |=> rsp_valid && rsp.write && pins.select_n)
        else $error("Write answer missing after the strobe rose.");

    a_read_wait_len: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(pins.select_n) && !op_write |-> !pins.select_n[*3]
            ##1 (pins.select_n && rsp_valid && !rsp.write))
        else $error("Read did not wait the access time plus synchroniser.");

    a_read_mode_pins: assert property (@(posedge clk) disable iff (!arst_n)
        rsp_valid && !rsp.write |-> !$past(pins.select_n) && $past(pins.write_strobe_n)
            && $past(pins.write_strobe_n, 3))
        else $error("Read answered without a select-low strobe-high cycle.");

    a_index_steady_access: assert property (@(posedge clk) disable iff (!arst_n)
        !pins.select_n && !$fell(pins.select_n)
            |-> $stable(pins.word_index))
        else $error("Index moved during an open access.");

    a_strobe_needs_select: assert property (@(posedge clk) disable iff (!arst_n)
        !pins.write_strobe_n
            |-> !pins.select_n && !$fell(pins.select_n))
        else $error("Strobe low without select settled a cycle earlier.");

    a_data_settled_fall: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(pins.write_strobe_n)
            |-> $stable(pins.write_data_in))
        else $error("Write data moved at the strobe fall.");

    a_answer_pins_idle: assert property (@(posedge clk) disable iff (!arst_n)
        rsp_valid
            |-> pins.select_n && pins.write_strobe_n)
        else $error("Answer given while the access was still open.");

endmodule

// *** testbench/asram_mem.sv ***
// Behavioural 1K x 4 asynchronous memory that answers the host on its pins.
module asram_mem (
    input wire asram_pkg::asram_pins_t pins, // Pins driven by the host.
    output logic [asram_pkg::DATA_W-1:0] read_data_out // Memory data outputs.
);
    timeunit 1ns;
    timeprecision 100ps;

    // Cells start unknown, so a read of an unwritten word gives nothing usable.
    logic [3:0] cells [asram_pkg::WORDS];

    // Outputs stay low when deselected or while writing.
    function automatic logic [3:0] view();
        if (pins.select_n !== 1'h0 || pins.write_strobe_n !== 1'h1) begin
            return 4'h0;
        end
        return cells[pins.word_index];
    endfunction

    initial read_data_out = 4'h0;

    always @(posedge pins.write_strobe_n) begin
        if (pins.select_n === 1'h0) begin
            cells[pins.word_index] = pins.write_data_in;
        end
    end

    // The value is taken when the delay runs out, so a write that lands later is seen.
    always @(pins.word_index) begin
        if (pins.select_n === 1'h0) begin
            fork
                #1.0 read_data_out = ~read_data_out;
                #2.7 read_data_out = view();
            join_none
        end
    end

    always @(pins.select_n or pins.write_strobe_n) begin
        fork
            #2.0 read_data_out = view();
        join_none
    end
endmodule

// *** testbench/test_asram_host.sv ***
// Self-checking bench for the memory host with a behavioural memory on its pins.
module test_asram_host;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk;
    logic arst_n;
    logic req_valid;
    asram_pkg::asram_req_t req;
    asram_pkg::asram_rsp_t rsp;
    logic rsp_valid;
    logic req_ready;
    asram_pkg::asram_pins_t pins;
    logic [3:0] read_data_out;
    logic [3:0] shadow [1024];
    bit known [1024];
    int miscompares;
    int n_checks;

    asram_host asram_host_inst (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req(req),
        .rsp(rsp), .rsp_valid(rsp_valid), .req_ready(req_ready), .pins(pins),
        .read_data_out(read_data_out));
    asram_mem asram_mem_inst (.pins(pins), .read_data_out(read_data_out));

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // The strobe is low only in the second cycle of a write access.
    function automatic logic exp_strobe(input logic w, input int n);
        return !(w && n == 2);
    endfunction

    // Called at a falling edge; the next request is offered on the answer cycle.
    task automatic op(input logic w, input logic [9:0] idx, input logic [3:0] d);
        int n;
        req_valid <= 1'h1;
        req <= '{write: w, index: idx, wdata: d};
        @(negedge clk);
        // A write to a random place while busy must be ignored.
        req <= '{write: 1'h1, index: 10'($urandom), wdata: 4'($urandom)};
        for (n = 1; n < 10 && rsp_valid !== 1'h1; n++) begin
            chk("ready", 16'(req_ready), 16'h0000);
            chk("select", 16'(pins.select_n), 16'h0000);
            chk("index", 16'(pins.word_index), 16'(idx));
            chk("strobe", 16'(pins.write_strobe_n), 16'(exp_strobe(w, n)));
            if (w) chk("wdata", 16'(pins.write_data_in), 16'(d));
            @(negedge clk);
        end
        if (n == 10) begin
            miscompares++;
            summarize();
        end
        chk("latency", 16'(n), 16'h0004);
        chk("rsp write", 16'(rsp.write), 16'(w));
        if (!w && known[idx]) chk("rdata", 16'(rsp.rdata), 16'(shadow[idx]));
        chk("select release", 16'(pins.select_n), 16'h0001);
        if (w) begin
            shadow[idx] = d;
            known[idx] = 1'b1;
        end
    endtask

    initial begin
        void'($urandom(80926));
        arst_n = 1'h0;
        req_valid = 1'h0;
        req = '0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("reset pins", 16'({pins.select_n, pins.write_strobe_n, req_ready}), 16'h0007);
        chk("reset rsp", 16'({rsp, rsp_valid}), 16'h0000);
        arst_n = 1'h1;
        @(negedge clk);
        // ****************************************************************
        // Corner cases: end indices, overwrite, read right after write
        // ****************************************************************
        op(1'h1, 10'h000, 4'hf);
        op(1'h1, 10'h3ff, 4'ha);
        op(1'h0, 10'h000, 4'h0);
        op(1'h0, 10'h3ff, 4'h0);
        op(1'h1, 10'h000, 4'h5);
        op(1'h0, 10'h000, 4'h0);
        op(1'h0, 10'h3ff, 4'h0);
        op(1'h1, 10'h3ff, 4'h0);
        op(1'h0, 10'h3ff, 4'h0);
        // ****************************************************************
        // Random mix over a small window of indices so reads hit writes
        // ****************************************************************
        repeat (300) begin
            op(1'($urandom), 10'($urandom_range(0, 31)), 4'($urandom));
        end
        req_valid <= 1'h0;
        repeat (3) @(negedge clk);
        chk("idle", 16'({pins.select_n, pins.write_strobe_n, req_ready}), 16'h0007);
        summarize();
    end
endmodule
